//--- shared/sksx_pkg.sv
package sksx_pkg;
    // ----------------------------------------------------------------
    // operations handled by this execution slice
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_NONE,
        OP_DEC_SKIP_ZERO,
        OP_DEC_SKIP_ZERO_TO_ACCUM,
        OP_SET_BYTE,
        OP_SET_BIT,
        OP_INC_SKIP_ZERO,
        OP_INC_SKIP_ZERO_TO_ACCUM,
        OP_BIT_SKIP_NONZERO,
        OP_SUB_MEM,
        OP_SUBTRACT_TO_MEMORY,
        OP_SUB_IMM,
        OP_NIBBLE_SWAP,
        OP_NIBBLE_SWAP_TO_ACCUM,
        OP_SKIP_IF_ZERO,
        OP_MOVE_SKIP_IF_ZERO,
        OP_BIT_SKIP_ZERO
    } sksx_op_t;

    // sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_TABLE_WAIT,
        ST_DUMMY
    } sksx_state_t;

    // ----------------------------------------------------------------
    // widths and constants
    // ----------------------------------------------------------------
    localparam int         DATA_W      = 8;
    localparam int         MADDR_W     = 8;
    localparam int         PADDR_W     = 16;
    localparam int         PWORD_W     = 16;
    localparam int         HIGH_W      = PWORD_W - DATA_W;
    localparam logic [7:0] BYTE_ONES   = 8'hFF;
    localparam logic [7:0] BYTE_ONE    = 8'h01;
    localparam logic [7:0] BYTE_ZERO   = 8'h00;
    localparam logic [7:0] ACC_RESET   = 8'h00;
    localparam logic [7:0] HIGH_RESET  = 8'h00;
    // flag vector positions: {signed_wrap, zero, half_carry, carry}
    localparam int         FLAG_C      = 0;
    localparam int         FLAG_AC     = 1;
    localparam int         FLAG_Z      = 2;
    localparam int         FLAG_OV     = 3;
    localparam logic [3:0] FLAG_RESET  = 4'h0;
    localparam int         NIB_LO      = 3;
    localparam int         NIB_HI      = 7;
endpackage : sksx_pkg

//--- rtl/sksx_sub_unit.sv
`timescale 1ns/1ps
module sksx_sub_unit
    import sksx_pkg::*;
(
    input  wire logic [7:0] minuend,
    input  wire logic [7:0] subtrahend,
    output logic      [7:0] diff,
    output logic      [3:0] flags
);
    // ----------------------------------------------------------------
    // subtract with borrow-style carry
    // ----------------------------------------------------------------
    logic [8:0] wide;
    logic [4:0] lowNib;

    // carry set means no borrow
    assign wide   = {1'b0, minuend} + {1'b0, ~subtrahend} + 9'h001;
    assign lowNib = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + 5'h01;
    assign diff   = wide[7:0];
    assign flags[FLAG_C]  = wide[8];
    assign flags[FLAG_AC] = lowNib[4];
    assign flags[FLAG_Z]  = (wide[7:0] == BYTE_ZERO);
    assign flags[FLAG_OV] = (minuend[7] ^ subtrahend[7]) & (minuend[7] ^ wide[7]);
endmodule : sksx_sub_unit

//--- rtl/sksx_cond_unit.sv
`timescale 1ns/1ps
module sksx_cond_unit
    import sksx_pkg::*;
(
    input  wire sksx_op_t   op,
    input  wire logic [7:0] memByte,
    input  wire logic [2:0] bitSel,
    output logic      [7:0] result,
    output logic            skip
);
    // ----------------------------------------------------------------
    // byte and bit results and skip conditions
    // ----------------------------------------------------------------
    logic [7:0] decVal;
    logic [7:0] incVal;
    logic [7:0] bitMask;
    logic [7:0] swapVal;
    logic       selBit;

    assign decVal  = memByte - BYTE_ONE;
    assign incVal  = memByte + BYTE_ONE;
    assign bitMask = BYTE_ONE << bitSel;
    assign swapVal = {memByte[NIB_LO:0], memByte[NIB_HI:NIB_LO+1]};
    assign selBit  = memByte[bitSel];

    // result selection
    always_comb begin
        result = memByte;
        skip   = 1'b0;
        case (op)
            OP_DEC_SKIP_ZERO, OP_DEC_SKIP_ZERO_TO_ACCUM: begin
                result = decVal;
                skip   = (decVal == BYTE_ZERO);
            end
            OP_INC_SKIP_ZERO, OP_INC_SKIP_ZERO_TO_ACCUM: begin
                result = incVal;
                skip   = (incVal == BYTE_ZERO);
            end
            OP_SET_BYTE:             result = BYTE_ONES;
            OP_SET_BIT:              result = memByte | bitMask;
            OP_NIBBLE_SWAP,
            OP_NIBBLE_SWAP_TO_ACCUM: result = swapVal;
            OP_BIT_SKIP_NONZERO:     skip   = selBit;
            OP_BIT_SKIP_ZERO:        skip   = ~selBit;
            OP_SKIP_IF_ZERO,
            OP_MOVE_SKIP_IF_ZERO:    skip   = (memByte == BYTE_ZERO);
            default: begin
                result = memByte;
                skip   = 1'b0;
            end
        endcase
    end
endmodule : sksx_cond_unit

//--- rtl/sksx_exec.sv
// What this block does
// - taken skip replaces the next instruction with one dummy cycle
// - decrement-skip writes byte minus one, skips on zero, no flags
// - accumulator decrement-skip loads byte minus one, memory kept, skip on zero
// - whole-byte set writes all ones, flags kept
// - bit set forces only the selected bit to one
// - increment-skip writes byte plus one, skips on zero, no flags
// - accumulator increment-skip loads byte plus one, memory kept, skip on zero
// - bit test skips when the selected bit is one
// - register subtraction puts accumulator minus byte in accumulator, updates flags
// - carry clears on borrow, sets when result zero or positive
// - subtract-to-memory writes difference to byte, accumulator kept, flags updated
// - immediate subtraction takes constant from accumulator, updates flags
// - nibble swap exchanges byte halves in place, flags kept
// - accumulator nibble swap loads swapped byte, memory and flags kept
// - byte-zero test skips when the byte is zero
// - move-and-test copies byte to accumulator, skips when zero
// - bit-zero test skips when the selected bit is zero
// - table address from high and low pointers, or low alone
// - table read stores low byte to memory, high part to latch
`timescale 1ns/1ps
module sksx_exec
    import sksx_pkg::*;
#(
    parameter bit HAS_HIGH_PTR = 1'b1
)
(
    input  wire logic             mclk,
    input  wire logic             arst_n,
    // issue from the sequencer
    input  wire logic             issueValid,
    input  wire sksx_op_t         issueOp,
    input  wire logic             issueTableRead,
    input  wire logic [7:0]       memAddr,
    input  wire logic [2:0]       bitSel,
    input  wire logic [7:0]       immData,
    input  wire logic [7:0]       memReadData,
    // table pointers
    input  wire logic [7:0]       tablePointerLow,
    input  wire logic [7:0]       tablePointerHigh,
    // program memory port
    output logic                  progReadReq,
    output logic [PADDR_W-1:0]    progAddr,
    input  wire logic             progReadValid,
    input  wire logic [PWORD_W-1:0] progReadData,
    // data memory write port
    output logic                  memWriteEn,
    output logic [7:0]            memWriteAddr,
    output logic [7:0]            memWriteData,
    // architectural state
    output logic [7:0]            accum,
    output logic [3:0]            statusFlags,
    output logic [HIGH_W-1:0]     tableReadHighLatch,
    // sequencing
    output logic                  ready,
    output logic                  skipTaken,
    output logic                  dummyCycle,
    output logic                  done
);

    // ----------------------------------------------------------------
    // usage notes
    // ----------------------------------------------------------------
    // issue taken on a rising edge with issueValid and ready high
    // memReadData holds the addressed byte during the issue cycle
    // non-table results appear one cycle after issue
    // memory write is a one-cycle pulse, address and data hold after it
    // skip-class ops never touch the status flags
    // subtract carry means no borrow, as does the half carry
    // a taken skip drops ready for exactly one dummy cycle
    // an issue during the dummy cycle is ignored, so re-issue after it
    // table read waits as long as the program memory needs
    // table destination captured at issue, pointers read while waiting
    // pointers must stay put until the program word arrives
    // issueOp is ignored while issueTableRead is high
    // subtraction reads the registered accumulator
    // so back-to-back subtracts chain without a bypass path
    // skipTaken and done are pulses, one cycle wide
    // dummyCycle is high for the whole dummy slot
    // progReadReq is high for the whole table wait
    // progAddr follows the pointers combinationally
    // without a high pointer the upper address byte is zero
    // tableReadHighLatch keeps the last table word's high byte
    // accum and statusFlags change only on a completed op
    // reset clears accumulator, flags and latch
    // no op here raises an interrupt or touches other flags
    // set-byte and set-bit forms write memory, never flags
    // in-place nibble swap writes memory, the accumulator form does not
    // increment and decrement wrap modulo 256
    // ----------------------------------------------------------------
    // local signals
    // ----------------------------------------------------------------
    // sequencer state
    sksx_state_t state_reg;
    sksx_state_t state_next;

    // architectural registers
    logic [7:0]         accum_reg;
    logic [7:0]         accum_next;
    logic [3:0]         flags_reg;
    logic [3:0]         flags_next;
    logic [HIGH_W-1:0]  high_reg;
    logic [HIGH_W-1:0]  high_next;

    // data memory write port registers
    logic               wrEn_reg;
    logic               wrEn_next;
    logic [7:0]         wrAddr_reg;
    logic [7:0]         wrAddr_next;
    logic [7:0]         wrData_reg;
    logic [7:0]         wrData_next;

    // one-cycle pulses and table destination
    logic               skip_reg;
    logic               skip_next;
    logic               done_reg;
    logic               done_next;
    logic [7:0]         tabAddr_reg;
    logic [7:0]         tabAddr_next;

    // datapath unit results
    logic [7:0]         condResult;
    logic               condSkip;
    logic [7:0]         subOperand;
    logic [7:0]         subDiff;
    logic [3:0]         subFlags;

    // decoded operation classes
    logic               isSub;
    logic               isMemWrite;
    logic               isAccWrite;
    logic               accept;

    // ----------------------------------------------------------------
    // datapath units
    // ----------------------------------------------------------------
    // byte and bit operations with skip test
    sksx_cond_unit u_cond (
        .op      (issueOp),
        .memByte (memReadData),
        .bitSel  (bitSel),
        .result  (condResult),
        .skip    (condSkip)
    );

    // immediate or memory operand
    assign subOperand = (issueOp == OP_SUB_IMM) ? immData : memReadData;

    // shared subtractor for all three forms
    sksx_sub_unit u_sub (
        .minuend    (accum_reg),
        .subtrahend (subOperand),
        .diff       (subDiff),
        .flags      (subFlags)
    );

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    // issue accepted only in idle
    assign accept = issueValid && (state_reg == ST_IDLE);
    // subtraction family
    assign isSub  = (issueOp == OP_SUB_MEM) || (issueOp == OP_SUBTRACT_TO_MEMORY)
                  || (issueOp == OP_SUB_IMM);
    // ops writing data memory
    assign isMemWrite = (issueOp == OP_DEC_SKIP_ZERO) || (issueOp == OP_INC_SKIP_ZERO)
                      || (issueOp == OP_SET_BYTE) || (issueOp == OP_SET_BIT)
                      || (issueOp == OP_NIBBLE_SWAP);
    // ops loading the accumulator
    assign isAccWrite = (issueOp == OP_DEC_SKIP_ZERO_TO_ACCUM)
                      || (issueOp == OP_INC_SKIP_ZERO_TO_ACCUM)
                      || (issueOp == OP_NIBBLE_SWAP_TO_ACCUM)
                      || (issueOp == OP_MOVE_SKIP_IF_ZERO);

    // table address from pointers
    assign progAddr = HAS_HIGH_PTR ? {tablePointerHigh, tablePointerLow}
                                   : {8'h00, tablePointerLow};
    assign progReadReq = (state_reg == ST_TABLE_WAIT);

    // ----------------------------------------------------------------
    // next-state and result logic
    // ----------------------------------------------------------------
    always_comb begin
        state_next   = state_reg;
        accum_next   = accum_reg;
        flags_next   = flags_reg;
        high_next    = high_reg;
        wrEn_next    = 1'b0;
        wrAddr_next  = wrAddr_reg;
        wrData_next  = wrData_reg;
        skip_next    = 1'b0;
        done_next    = 1'b0;
        tabAddr_next = tabAddr_reg;
        case (state_reg)
            // issue: table read or single-cycle op
            ST_IDLE: begin
                if (accept && issueTableRead) begin
                    tabAddr_next = memAddr;
                    state_next   = ST_TABLE_WAIT;
                end else if (accept) begin
                    done_next = 1'b1;
                    // subtraction updates all four flags
                    if (isSub) begin
                        flags_next = subFlags;
                        if (issueOp == OP_SUBTRACT_TO_MEMORY) begin
                            wrEn_next   = 1'b1;
                            wrAddr_next = memAddr;
                            wrData_next = subDiff;
                        end else begin
                            accum_next = subDiff;
                        end
                    end
                    // byte results back to data memory
                    if (isMemWrite) begin
                        wrEn_next   = 1'b1;
                        wrAddr_next = memAddr;
                        wrData_next = condResult;
                    end
                    // byte results into the accumulator
                    if (isAccWrite) begin
                        accum_next = condResult;
                    end
                    // taken skip: hold off the next issue one cycle
                    if (condSkip) begin
                        skip_next  = 1'b1;
                        state_next = ST_DUMMY;
                    end else begin
                        state_next = ST_IDLE;
                    end
                end
            end
            // wait for the program word, then split it
            ST_TABLE_WAIT: begin
                if (progReadValid) begin
                    wrEn_next   = 1'b1;
                    wrAddr_next = tabAddr_reg;
                    wrData_next = progReadData[DATA_W-1:0];
                    high_next   = progReadData[PWORD_W-1:DATA_W];
                    done_next   = 1'b1;
                    state_next  = ST_IDLE;
                end
            end
            // dummy slot in place of the skipped instruction
            ST_DUMMY: begin
                state_next = ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // all state, cleared by the asynchronous reset
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg   <= ST_IDLE;
            accum_reg   <= ACC_RESET;
            flags_reg   <= FLAG_RESET;
            high_reg    <= HIGH_RESET;
            wrEn_reg    <= 1'b0;
            wrAddr_reg  <= BYTE_ZERO;
            wrData_reg  <= BYTE_ZERO;
            skip_reg    <= 1'b0;
            done_reg    <= 1'b0;
            tabAddr_reg <= BYTE_ZERO;
        end else begin
            state_reg   <= state_next;
            accum_reg   <= accum_next;
            flags_reg   <= flags_next;
            high_reg    <= high_next;
            wrEn_reg    <= wrEn_next;
            wrAddr_reg  <= wrAddr_next;
            wrData_reg  <= wrData_next;
            skip_reg    <= skip_next;
            done_reg    <= done_next;
            tabAddr_reg <= tabAddr_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // architectural state
    assign accum              = accum_reg;
    assign statusFlags        = flags_reg;
    assign tableReadHighLatch = high_reg;

    // data memory write port
    assign memWriteEn         = wrEn_reg;
    assign memWriteAddr       = wrAddr_reg;
    assign memWriteData       = wrData_reg;

    // sequencing
    assign skipTaken          = skip_reg;
    assign done               = done_reg;
    assign dummyCycle         = (state_reg == ST_DUMMY);
    assign ready              = (state_reg == ST_IDLE);
endmodule : sksx_exec

//--- sim/sksx_exec_assertions.sv
`timescale 1ns/1ps
module sksx_exec_assertions #(
    parameter bit HAS_HIGH_PTR = 1'b1
)
(
    input wire logic              mclk,
    input wire logic              arst_n,
    input wire logic              issueValid,
    input wire sksx_pkg::sksx_op_t issueOp,
    input wire logic              issueTableRead,
    input wire logic [7:0]        immData,
    input wire logic [7:0]        memReadData,
    input wire logic [7:0]        tablePointerLow,
    input wire logic [7:0]        tablePointerHigh,
    input wire logic              progReadReq,
    input wire logic [15:0]       progAddr,
    input wire logic              progReadValid,
    input wire logic [15:0]       progReadData,
    input wire logic              memWriteEn,
    input wire logic [7:0]        memWriteData,
    input wire logic [7:0]        accum,
    input wire logic [3:0]        statusFlags,
    input wire logic [7:0]        tableReadHighLatch,
    input wire logic              ready,
    input wire logic              skipTaken,
    input wire logic              dummyCycle,
    input wire logic              done
);
    import sksx_pkg::*;
    // accepted non-table issue
    wire take = issueValid && ready && !issueTableRead;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);
    // ----------------------------------------------------------------
    // sequencing and results
    // ----------------------------------------------------------------
    skip_dummy_a: assert property (skipTaken |-> dummyCycle && !ready)
        else $error("taken skip without dummy cycle");
    dummy_once_a: assert property (skipTaken |=> ready && !dummyCycle)
        else $error("dummy cycle longer than one");
    answer_next_a: assert property (take |=> done && (skipTaken || ready))
        else $error("result not one cycle after issue");
    dec_write_a: assert property (take && issueOp == OP_DEC_SKIP_ZERO |=> memWriteEn
        && memWriteData == $past(memReadData) - 8'h01 && skipTaken == ($past(memReadData) == 8'h01))
        else $error("decrement skip result wrong");
    inc_accum_a: assert property (take && issueOp == OP_INC_SKIP_ZERO_TO_ACCUM |=>
        !memWriteEn && accum == $past(memReadData) + 8'h01 && $stable(statusFlags))
        else $error("increment to accumulator wrong");
    set_byte_a: assert property (take && issueOp == OP_SET_BYTE |=> memWriteEn
        && memWriteData == BYTE_ONES && $stable(statusFlags))
        else $error("byte set wrong");
    swap_accum_a: assert property (take && issueOp == OP_NIBBLE_SWAP_TO_ACCUM |=>
        !memWriteEn && accum == {$past(memReadData[3:0]), $past(memReadData[7:4])})
        else $error("nibble swap to accumulator wrong");
    sub_carry_a: assert property (take && issueOp == OP_SUB_IMM |=>
        statusFlags[FLAG_C] == ($past(accum) >= $past(immData)))
        else $error("subtract carry wrong");
    table_addr_a: assert property (progReadReq |-> progAddr == (HAS_HIGH_PTR ?
        {tablePointerHigh, tablePointerLow} : {8'h00, tablePointerLow}))
        else $error("table address wrong");
    table_store_a: assert property (progReadReq && progReadValid |=> done && memWriteEn
        && memWriteData == $past(progReadData[7:0])
        && tableReadHighLatch == $past(progReadData[15:8]))
        else $error("table word split wrong");
endmodule : sksx_exec_assertions

//--- sim/sksx_exec_tb_top.sv
`timescale 1ns/1ps
module sksx_exec_tb_top;
    import sksx_pkg::*;
    logic mclk = 1'b0, arst_n, issueValid, issueTableRead, progReadValid;
    sksx_op_t issueOp;
    logic [7:0] memAddr, immData, memReadData, tablePointerLow, tablePointerHigh;
    logic [2:0] bitSel;
    logic [15:0] progReadData, progAddr;
    logic progReadReq, memWriteEn, ready, skipTaken, dummyCycle, done;
    logic [7:0] memWriteAddr, memWriteData, accum, tableReadHighLatch;
    logic [3:0] statusFlags, flagM = 4'h0;
    int bad_count = 0, checks = 0, cycles = 0, accM = 0;
    sksx_exec sksx_exec_i (.mclk(mclk), .arst_n(arst_n), .issueValid(issueValid),
        .issueOp(issueOp), .issueTableRead(issueTableRead), .memAddr(memAddr),
        .bitSel(bitSel), .immData(immData), .memReadData(memReadData),
        .tablePointerLow(tablePointerLow), .tablePointerHigh(tablePointerHigh),
        .progReadReq(progReadReq), .progAddr(progAddr), .progReadValid(progReadValid),
        .progReadData(progReadData), .memWriteEn(memWriteEn), .memWriteAddr(memWriteAddr),
        .memWriteData(memWriteData), .accum(accum), .statusFlags(statusFlags),
        .tableReadHighLatch(tableReadHighLatch), .ready(ready), .skipTaken(skipTaken),
        .dummyCycle(dummyCycle), .done(done));
    // clock and hang guard
    always #2.5 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            final_report();
        end
    end
    task automatic final_report();
        if (bad_count == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : final_report
    task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : check
    // model subtraction: {OV,Z,AC,C}, C and AC mean no borrow
    function automatic int sub_model(input int a, input int s);
        int d;
        d = (a - s) & 255;
        flagM = {((a ^ s) & (a ^ d) & 128) != 0, d == 0, (a & 15) >= (s & 15), a >= s};
        return d;
    endfunction : sub_model
    task automatic run_op(input sksx_op_t op, input logic [7:0] m, input logic [2:0] b);
        int r = 0, wr = 0, sk = 0;
        {immData, memAddr} = 16'($urandom);
        issueOp = op;
        memReadData = m;
        bitSel = b;
        issueValid = 1'b1;
        case (op)
            OP_DEC_SKIP_ZERO: begin r = (m - 1) & 255; wr = 1; sk = r == 0; end
            OP_DEC_SKIP_ZERO_TO_ACCUM: begin accM = (m - 1) & 255; sk = accM == 0; end
            OP_SET_BYTE: begin r = 255; wr = 1; end
            OP_SET_BIT: begin r = m | (1 << b); wr = 1; end
            OP_INC_SKIP_ZERO: begin r = (m + 1) & 255; wr = 1; sk = r == 0; end
            OP_INC_SKIP_ZERO_TO_ACCUM: begin accM = (m + 1) & 255; sk = accM == 0; end
            OP_BIT_SKIP_NONZERO: sk = m[b];
            OP_SUB_MEM: accM = sub_model(accM, m);
            OP_SUBTRACT_TO_MEMORY: begin r = sub_model(accM, m); wr = 1; end
            OP_SUB_IMM: accM = sub_model(accM, immData);
            OP_NIBBLE_SWAP: begin r = {m[3:0], m[7:4]}; wr = 1; end
            OP_NIBBLE_SWAP_TO_ACCUM: accM = {m[3:0], m[7:4]};
            OP_SKIP_IF_ZERO: sk = m == 0;
            OP_MOVE_SKIP_IF_ZERO: begin accM = m; sk = m == 0; end
            default: sk = !m[b];
        endcase
        @(negedge mclk);
        check("done", 1, done);
        check("skipTaken", sk, skipTaken);
        check("memWriteEn", wr, memWriteEn);
        if (wr != 0) check("memWriteData", r, memWriteData);
        if (wr != 0) check("memWriteAddr", memAddr, memWriteAddr);
        check("accum", accM, accum);
        check("statusFlags", flagM, statusFlags);
        check("ready", sk == 0, ready);
        if (sk != 0) begin
            issueValid = 1'b0;
            check("dummyCycle", 1, dummyCycle);
            @(negedge mclk);
            check("readyAfterDummy", 1, ready);
        end
    endtask : run_op
    task automatic run_table(input int stall);
        logic [15:0] w = 16'($urandom);
        {tablePointerHigh, tablePointerLow, memAddr} = 24'($urandom);
        issueTableRead = 1'b1;
        issueValid = 1'b1;
        @(negedge mclk);
        issueValid = 1'b0;
        repeat (stall) begin
            check("progReadReq", 1, progReadReq);
            check("progAddr", {tablePointerHigh, tablePointerLow}, progAddr);
            @(negedge mclk);
        end
        progReadValid = 1'b1;
        progReadData = w;
        @(negedge mclk);
        progReadValid = 1'b0;
        issueTableRead = 1'b0;
        check("tableLow", w[7:0], memWriteData);
        check("tableAddr", memAddr, memWriteAddr);
        check("tableHigh", w[15:8], tableReadHighLatch);
        check("tableDone", 3'h7, {memWriteEn, done, ready});
        check("tableFlags", {accM[7:0], flagM}, {accum, statusFlags});
    endtask : run_table
    // main sequence: every operation with boundary and random bytes
    initial begin
        logic [7:0] mv;
        void'($urandom(57));
        {arst_n, issueValid, issueTableRead, progReadValid} = 4'h0;
        {memAddr, immData, memReadData, bitSel, progReadData} = 43'h0;
        {tablePointerLow, tablePointerHigh} = 16'h0;
        issueOp = OP_NONE;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        arst_n = 1'b1;
        check("resetState", {accum, statusFlags, ready}, 13'h0001);
        for (int k = 0; k < 8; k++) begin
            for (int o = 1; o < 16; o++) begin
                mv = (k == 0) ? 8'h01 : (k == 1) ? 8'hFF : (k == 2) ? 8'h00 : 8'($urandom);
                run_op(sksx_op_t'(o), mv, 3'($urandom));
            end
            run_table(1 + ($urandom % 3));
        end
        final_report();
    end
endmodule : sksx_exec_tb_top
bind sksx_exec sksx_exec_assertions #(.HAS_HIGH_PTR(HAS_HIGH_PTR)) sksx_exec_assertions_i (
    .mclk(mclk), .arst_n(arst_n), .issueValid(issueValid), .issueOp(issueOp),
    .issueTableRead(issueTableRead), .immData(immData), .memReadData(memReadData),
    .tablePointerLow(tablePointerLow), .tablePointerHigh(tablePointerHigh),
    .progReadReq(progReadReq), .progAddr(progAddr), .progReadValid(progReadValid),
    .progReadData(progReadData), .memWriteEn(memWriteEn), .memWriteData(memWriteData),
    .accum(accum), .statusFlags(statusFlags), .tableReadHighLatch(tableReadHighLatch),
    .ready(ready), .skipTaken(skipTaken), .dummyCycle(dummyCycle), .done(done));
